// >>> verilog/efb_stage.sv
`default_nettype none
module efb_stage
	import efb_pkg::*;
#(
	parameter int MEAS_W   = 16,
	parameter int MS_COUNT = MS_CLKS
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	// measurement and blocking matrix
	input  wire logic [MEAS_W-1:0] meas_mag,
	input  wire logic [MEAS_W-1:0] harm2_mag,
	input  wire logic [MEAS_W-1:0] fund_mag,
	input  wire logic              block_in,
	input  wire logic [1:0]        fault_phase,
	input  wire logic              fault_gnd,
	input  wire logic              fault_fwd,
	input  wire logic [2:0]        setting_group,
	// stage outputs
	output logic                   start_out,
	output logic                   trip_out,
	output logic                   blocked_out,
	output logic [EVT_N-1:0]       evt_out,
	output logic [31:0]            evt_time,
	output logic                   irq
);
	// ----------------------------------------
	// time base
	// ----------------------------------------
	logic [31:0] ms_cnt;
	logic [7:0]  cyc_cnt;
	logic [31:0] tstamp;
	logic        ms_tick;
	logic        tick;
	wire logic   ms_wrap  = (ms_cnt == 32'(MS_COUNT - 1));
	wire logic   cyc_wrap = (cyc_cnt == 8'(CYCLE_MS - 1));

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ms_cnt  <= 32'h0;
			cyc_cnt <= 8'h0;
			tstamp  <= 32'h0;
			ms_tick <= 1'b0;
			tick    <= 1'b0;
		end else begin
			ms_cnt  <= ms_wrap ? 32'h0 : ms_cnt + 32'h1;
			ms_tick <= ms_wrap;
			tick    <= ms_tick & cyc_wrap;
			if (ms_tick) begin
				cyc_cnt <= cyc_wrap ? 8'h0 : cyc_cnt + 8'h1;
				tstamp  <= tstamp + 32'h1;
			end
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic              idmt_mode;
	logic              inrush_en;
	logic [15:0]       pickup_set;
	logic [15:0]       delay_set;
	logic [15:0]       release_set;
	logic [15:0]       harm_limit;
	logic [EVT_N-1:0]  evt_mask;
	logic [EVT_N-1:0]  irq_mask;
	logic [3:0]        rec_sel;
	wire logic         wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
	wire logic         clr_cnt  = wr_ctrl && reg_wdata[CTRL_CLRCNT];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			idmt_mode   <= 1'b0;
			inrush_en   <= 1'b0;
			pickup_set  <= PICKUP_RST;
			delay_set   <= DELAY_RST;
			release_set <= RELEASE_RST;
			harm_limit  <= HLIMIT_RST;
			evt_mask    <= EVTMASK_RST;
			irq_mask    <= '0;
			rec_sel     <= 4'h0;
		end else if (reg_wr) begin
			if (reg_addr == REG_CTRL) begin
				idmt_mode <= reg_wdata[CTRL_IDMT];
				inrush_en <= reg_wdata[CTRL_INRUSH];
			end else if (reg_addr == REG_PICKUP) begin
				pickup_set <= reg_wdata[15:0];
			end else if (reg_addr == REG_DELAY) begin
				delay_set <= reg_wdata[15:0];
			end else if (reg_addr == REG_RELEASE) begin
				release_set <= reg_wdata[15:0];
			end else if (reg_addr == REG_HLIMIT) begin
				harm_limit <= reg_wdata[15:0];
			end else if (reg_addr == REG_EVTMASK) begin
				evt_mask <= reg_wdata[EVT_N-1:0];
			end else if (reg_addr == REG_IRQMASK) begin
				irq_mask <= reg_wdata[EVT_N-1:0];
			end else if (reg_addr == REG_RECSEL) begin
				rec_sel <= reg_wdata[3:0];
			end
		end
	end

	// ----------------------------------------
	// pick-up, blocking and start decision
	// ----------------------------------------
	logic        pick;
	logic        inhib;
	logic        blk_s;
	logic [31:0] acc;
	logic [15:0] rel_cnt;
	wire logic [31:0] meas_pct  = 32'(meas_mag) * 32'(PCT_FULL);
	wire logic [31:0] set_pct   = 32'(pickup_set) * 32'(RESET_PCT);
	wire logic next_pick  = pick ? !(meas_pct < set_pct) : (32'(meas_mag) > 32'(pickup_set));
	wire logic next_inhib = next_pick & (inhib | block_in);
	wire logic next_start = next_pick & !next_inhib;
	wire logic next_blk   = next_pick & block_in;
	wire logic [47:0] harm_l = 48'(harm2_mag) * 48'(HARM_SCALE);
	wire logic [47:0] harm_r = 48'(fund_mag) * 48'(harm_limit);
	wire logic inrush_blk = inrush_en && (harm_l > harm_r);
	wire logic [31:0] target = idmt_mode ? 32'(pickup_set) * 32'(delay_set) : 32'(delay_set);
	wire logic [31:0] step   = idmt_mode ? 32'(meas_mag) : 32'h1;
	wire logic [31:0] acc_up = (acc + step > target) ? target : acc + step;
	wire logic reached    = next_start && (acc_up >= target);
	wire logic next_trip  = reached && !inrush_blk;
	wire logic [31:0] remain = target - acc;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pick        <= 1'b0;
			inhib       <= 1'b0;
			blk_s       <= 1'b0;
			start_out   <= 1'b0;
			trip_out    <= 1'b0;
			blocked_out <= 1'b0;
			acc         <= 32'h0;
			rel_cnt     <= 16'h0;
		end else if (tick) begin
			blk_s       <= block_in;
			pick        <= next_pick;
			inhib       <= next_inhib;
			start_out   <= next_start;
			trip_out    <= next_trip;
			blocked_out <= next_blk;
			if (next_start) begin
				acc     <= acc_up;
				rel_cnt <= 16'h0;
			end else if (acc != 32'h0) begin
				// release time runs the same after block or pick-up loss
				if (rel_cnt >= release_set) begin
					acc     <= 32'h0;
					rel_cnt <= 16'h0;
				end else begin
					rel_cnt <= rel_cnt + 16'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// events, counters, interrupt
	// ----------------------------------------
	wire logic [EVT_N-1:0] edges = {
		blocked_out & !next_blk, !blocked_out & next_blk,
		trip_out & !next_trip, !trip_out & next_trip,
		start_out & !next_start, !start_out & next_start};
	wire logic [EVT_N-1:0] ev_now = tick ? edges : '0;
	logic [15:0]      cnt_start;
	logic [15:0]      cnt_trip;
	logic [15:0]      cnt_blk;
	logic [EVT_N-1:0] irq_stat;
	wire logic        rd_stat = reg_rd && (reg_addr == REG_IRQSTAT);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			evt_out   <= '0;
			evt_time  <= 32'h0;
			cnt_start <= 16'h0;
			cnt_trip  <= 16'h0;
			cnt_blk   <= 16'h0;
			irq_stat  <= '0;
			irq       <= 1'b0;
		end else begin
			evt_out <= ev_now & evt_mask;
			if (tick) begin
				evt_time <= tstamp;
			end
			if (clr_cnt) begin
				cnt_start <= 16'h0;
				cnt_trip  <= 16'h0;
				cnt_blk   <= 16'h0;
			end else begin
				cnt_start <= cnt_start + 16'(ev_now[EV_START_ON]);
				cnt_trip  <= cnt_trip + 16'(ev_now[EV_TRIP_ON]);
				cnt_blk   <= cnt_blk + 16'(ev_now[EV_BLK_ON]);
			end
			// new event wins over the read clear
			irq_stat <= (rd_stat ? '0 : irq_stat) | ev_now;
			irq      <= |(((rd_stat ? '0 : irq_stat) | ev_now) & irq_mask);
		end
	end

	// ----------------------------------------
	// measurement history and fault records
	// ----------------------------------------
	logic [MEAS_W-1:0] hist [PRE_FAULT_TICKS];
	logic [31:0]       rec_time [REC_DEPTH];
	logic [8:0]        rec_info [REC_DEPTH];
	logic [MEAS_W-1:0] rec_pre  [REC_DEPTH];
	logic [MEAS_W-1:0] rec_flt  [REC_DEPTH];
	logic [MEAS_W-1:0] rec_prf  [REC_DEPTH];
	logic [31:0]       rec_rem  [REC_DEPTH];
	logic [3:0]        wr_ptr;
	logic [3:0]        rec_cnt;
	efb_rec_t          rec_kind;
	always_comb begin
		if (ev_now[EV_TRIP_ON]) begin
			rec_kind = EFB_REC_TRIP;
		end else if (ev_now[EV_START_ON]) begin
			rec_kind = EFB_REC_START;
		end else if (ev_now[EV_BLK_ON]) begin
			rec_kind = EFB_REC_BLK;
		end else begin
			rec_kind = EFB_REC_NONE;
		end
	end
	wire logic rec_wr = (rec_kind != EFB_REC_NONE);
	wire logic [3:0] ftype = {fault_phase, fault_gnd, fault_fwd};

	always_ff @(posedge core_clk) begin
		if (tick) begin
			hist[0] <= meas_mag;
		end
	end
	genvar gi;
	generate
		for (gi = 1; gi < PRE_FAULT_TICKS; gi++) begin : g_hist
			always_ff @(posedge core_clk) begin
				if (tick) begin
					hist[gi] <= hist[gi-1];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rec_wr) begin
			rec_time[wr_ptr] <= tstamp;
			rec_info[wr_ptr] <= {setting_group, ftype, rec_kind};
			rec_pre[wr_ptr]  <= hist[PRE_TRIG_TICKS-1];
			rec_flt[wr_ptr]  <= meas_mag;
			rec_prf[wr_ptr]  <= hist[PRE_FAULT_TICKS-1];
			rec_rem[wr_ptr]  <= next_trip ? 32'h0 : remain;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr  <= 4'h0;
			rec_cnt <= 4'h0;
		end else if (rec_wr) begin
			wr_ptr  <= (wr_ptr == 4'(REC_DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1;
			if (rec_cnt != 4'(REC_DEPTH)) begin
				rec_cnt <= rec_cnt + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	wire logic       sel_ok = (rec_sel < 4'(REC_DEPTH));
	wire logic [3:0] ri     = sel_ok ? rec_sel : 4'h0;
	logic [31:0]     rd_val;
	always_comb begin
		if (reg_addr == REG_CTRL) begin
			rd_val = {30'h0, inrush_en, idmt_mode};
		end else if (reg_addr == REG_PICKUP) begin
			rd_val = {16'h0, pickup_set};
		end else if (reg_addr == REG_DELAY) begin
			rd_val = {16'h0, delay_set};
		end else if (reg_addr == REG_RELEASE) begin
			rd_val = {16'h0, release_set};
		end else if (reg_addr == REG_HLIMIT) begin
			rd_val = {16'h0, harm_limit};
		end else if (reg_addr == REG_EVTMASK) begin
			rd_val = {26'h0, evt_mask};
		end else if (reg_addr == REG_IRQSTAT) begin
			rd_val = {26'h0, irq_stat};
		end else if (reg_addr == REG_IRQMASK) begin
			rd_val = {26'h0, irq_mask};
		end else if (reg_addr == REG_STATUS) begin
			rd_val = {19'h0, rec_cnt, wr_ptr, blk_s, pick, blocked_out, trip_out, start_out};
		end else if (reg_addr == REG_CNTSTART) begin
			rd_val = {16'h0, cnt_start};
		end else if (reg_addr == REG_CNTTRIP) begin
			rd_val = {16'h0, cnt_trip};
		end else if (reg_addr == REG_CNTBLK) begin
			rd_val = {16'h0, cnt_blk};
		end else if (reg_addr == REG_RECSEL) begin
			rd_val = {28'h0, rec_sel};
		end else if (reg_addr == REG_RECTIME && sel_ok) begin
			rd_val = rec_time[ri];
		end else if (reg_addr == REG_RECINFO && sel_ok) begin
			rd_val = {23'h0, rec_info[ri]};
		end else if (reg_addr == REG_RECPRE && sel_ok) begin
			rd_val = 32'(rec_pre[ri]);
		end else if (reg_addr == REG_RECFLT && sel_ok) begin
			rd_val = 32'(rec_flt[ri]);
		end else if (reg_addr == REG_RECPRF && sel_ok) begin
			rd_val = 32'(rec_prf[ri]);
		end else if (reg_addr == REG_RECREM && sel_ok) begin
			rd_val = rec_rem[ri];
		end else if (reg_addr == REG_TIME) begin
			rd_val = tstamp;
		end else begin
			rd_val = 32'h0;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_rd ? rd_val : 32'h0;
		end
	end
endmodule : efb_stage
`default_nettype wire

// >>> verilog/efb_pkg.sv
// How it works
// - block input sampled once per program cycle
// - pick-up without block raises start, timing
// - optional second-harmonic inrush blocks trip only
// - harmonic limit set in 0.01 percent steps
// - block at pick-up gives blocked, no start
// - block during start drops start, release runs
// - definite or inverse time characteristic selectable
// - six on/off events for start, trip, blocked
// - per event on/off storage selection mask
// - events carry time stamp of occurrence
// - clearable counters for start, trip, blocked
// - twelve-deep circular fault record store
// - record holds time, event, currents, group
// - pick-up above level, release below 97 percent
// - fault type holds phase, ground, direction
`default_nettype none
package efb_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ         = 100;
	localparam int MS_NS           = 1000000;
	localparam int CLK_NS          = 1000 / CLK_MHZ;
	localparam int MS_CLKS         = MS_NS / CLK_NS;
	localparam int CYCLE_MS        = 5;
	localparam int BLOCK_LEAD_MS   = 5;
	localparam int PRE_TRIG_MS     = 20;
	localparam int PRE_FAULT_MS    = 200;
	localparam int PRE_TRIG_TICKS  = PRE_TRIG_MS / CYCLE_MS;
	localparam int PRE_FAULT_TICKS = PRE_FAULT_MS / CYCLE_MS;
	// ----------------------------------------
	// thresholds and sizes
	// ----------------------------------------
	localparam int RESET_PCT   = 97;
	localparam int PCT_FULL    = 100;
	localparam int HARM_SCALE  = 10000;
	localparam int REC_DEPTH   = 12;
	localparam int EVT_N       = 6;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_PICKUP   = 8'h04;
	localparam logic [7:0] REG_DELAY    = 8'h08;
	localparam logic [7:0] REG_RELEASE  = 8'h0c;
	localparam logic [7:0] REG_HLIMIT   = 8'h10;
	localparam logic [7:0] REG_EVTMASK  = 8'h14;
	localparam logic [7:0] REG_IRQSTAT  = 8'h18;
	localparam logic [7:0] REG_IRQMASK  = 8'h1c;
	localparam logic [7:0] REG_STATUS   = 8'h20;
	localparam logic [7:0] REG_CNTSTART = 8'h24;
	localparam logic [7:0] REG_CNTTRIP  = 8'h28;
	localparam logic [7:0] REG_CNTBLK   = 8'h2c;
	localparam logic [7:0] REG_RECSEL   = 8'h30;
	localparam logic [7:0] REG_RECTIME  = 8'h34;
	localparam logic [7:0] REG_RECINFO  = 8'h38;
	localparam logic [7:0] REG_RECPRE   = 8'h3c;
	localparam logic [7:0] REG_RECFLT   = 8'h40;
	localparam logic [7:0] REG_RECPRF   = 8'h44;
	localparam logic [7:0] REG_RECREM   = 8'h48;
	localparam logic [7:0] REG_TIME     = 8'h4c;
	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int CTRL_IDMT    = 0;
	localparam int CTRL_INRUSH  = 1;
	localparam int CTRL_CLRCNT  = 2;
	localparam logic [15:0] PICKUP_RST  = 16'h04b0;
	localparam logic [15:0] DELAY_RST   = 16'h0014;
	localparam logic [15:0] RELEASE_RST = 16'h0000;
	localparam logic [15:0] HLIMIT_RST  = 16'h0001;
	localparam logic [5:0]  EVTMASK_RST = 6'h3f;
	// event bit order: start on/off, trip on/off, block on/off
	localparam int EV_START_ON = 0;
	localparam int EV_TRIP_ON  = 2;
	localparam int EV_BLK_ON   = 4;
	typedef enum logic [1:0] {
		EFB_REC_NONE  = 2'h0,
		EFB_REC_START = 2'h1,
		EFB_REC_TRIP  = 2'h3,
		EFB_REC_BLK   = 2'h2
	} efb_rec_t;
endpackage : efb_pkg
`default_nettype wire

// >>> bench/efb_far_model.sv
`default_nettype none
module efb_far_model
	import efb_pkg::*;
(
	// clock and wishes of the bench
	input  wire logic        core_clk,
	input  wire logic [15:0] want_meas,
	input  wire logic        want_block,
	input  wire logic [15:0] want_harm,
	// levels towards the stage
	output logic      [15:0] meas_mag,
	output logic      [15:0] harm2_mag,
	output logic      [15:0] fund_mag,
	output logic             block_in,
	output logic      [1:0]  fault_phase,
	output logic             fault_gnd,
	output logic             fault_fwd,
	output logic      [2:0]  setting_group
);
	// block follows one clock later, in step with the measurement
	always_ff @(posedge core_clk) begin
		meas_mag <= want_meas;
		block_in <= want_block;
	end
	// fixed fundamental, harmonic content from the bench
	assign harm2_mag     = want_harm;
	assign fund_mag      = 16'h0064;
	assign fault_phase   = 2'h2;
	assign fault_gnd     = 1'h1;
	assign fault_fwd     = 1'h1;
	assign setting_group = 3'h5;
endmodule : efb_far_model
`default_nettype wire

// >>> bench/efb_stage_monitor.sv
`default_nettype none
module efb_stage_monitor
	import efb_pkg::*;
(
	// clock and reset
	input wire logic             core_clk,
	input wire logic             sys_rst,
	// register port
	input wire logic             reg_rd,
	input wire logic [31:0]      reg_rdata,
	// stage outputs
	input wire logic             start_out,
	input wire logic             trip_out,
	input wire logic             blocked_out,
	input wire logic [EVT_N-1:0] evt_out,
	input wire logic [31:0]      evt_time
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_start_rise;
		$rose(start_out);
	endsequence
	sequence s_quiet;
		($stable(start_out) && $stable(blocked_out)) [*8];
	endsequence
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read answer cycle");
	AST_TICK_SPACING: assert property (($changed(start_out) || $changed(blocked_out)) |=> s_quiet)
		else $error("start or blocked changed between ticks");
	AST_START_EXCL: assert property (!(start_out && blocked_out))
		else $error("start and blocked together");
	AST_TRIP_START: assert property (trip_out |-> start_out)
		else $error("trip without start");
	AST_START_EVT: assert property (evt_out[EV_START_ON] |-> s_start_rise)
		else $error("start on event without start edge");
	AST_START_OFF: assert property (evt_out[EV_START_ON+1] |-> $fell(start_out))
		else $error("start off event without falling start");
	AST_TRIP_EVT: assert property (evt_out[EV_TRIP_ON] |-> $rose(trip_out))
		else $error("trip on event without trip edge");
	AST_BLK_EVT: assert property (evt_out[EV_BLK_ON] |-> $rose(blocked_out))
		else $error("block on event without blocked edge");
	AST_EVT_PULSE: assert property (evt_out != 6'h00 |=> evt_out == 6'h00)
		else $error("event pulse longer than one cycle");
	AST_EVT_STAMP: assert property (evt_out != 6'h00 |-> $changed(evt_time))
		else $error("event without fresh time stamp");
endmodule : efb_stage_monitor
bind efb_stage efb_stage_monitor i_mon (.core_clk(core_clk), .sys_rst(sys_rst), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
	.evt_out(evt_out), .evt_time(evt_time));
`default_nettype wire

// >>> bench/tb_efb_stage.sv
`default_nettype none
module tb_efb_stage
	import efb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, want_block = 0, start_out, trip_out, blocked_out, irq;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, evt_time, v;
	logic [15:0] want_meas = 16'h0000, want_harm = 16'h0000, meas_mag, harm2_mag, fund_mag;
	logic [5:0] evt_out;
	logic [1:0] fault_phase;
	logic [2:0] setting_group;
	logic fault_gnd, fault_fwd, block_in;
	int failures = 0, total_checks = 0;
	always #5 core_clk = ~core_clk;
	efb_far_model i_far (.core_clk(core_clk), .want_meas(want_meas), .want_block(want_block), .want_harm(want_harm),
		.meas_mag(meas_mag), .harm2_mag(harm2_mag), .fund_mag(fund_mag), .block_in(block_in),
		.fault_phase(fault_phase), .fault_gnd(fault_gnd), .fault_fwd(fault_fwd), .setting_group(setting_group));
	efb_stage #(.MS_COUNT(10)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_mag(meas_mag),
		.harm2_mag(harm2_mag), .fund_mag(fund_mag), .block_in(block_in), .fault_phase(fault_phase),
		.fault_gnd(fault_gnd), .fault_fwd(fault_fwd), .setting_group(setting_group), .start_out(start_out),
		.trip_out(trip_out), .blocked_out(blocked_out), .evt_out(evt_out), .evt_time(evt_time), .irq(irq));
	// ----------------------------------------
	// access and compare
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		#200us;
		failures++;
		finish_test();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(REG_PICKUP);
		chk("pickup reset", v, 32'h000004b0);
		rd(REG_DELAY);
		chk("delay reset", v, 32'h00000014);
		rd(REG_EVTMASK);
		chk("evtmask reset", v, 32'h0000003f);
		rd(8'h50);
		chk("unmapped", v, 32'h0);
		wr(REG_PICKUP, 32'h64);
		wr(REG_DELAY, 32'h3);
		wr(REG_IRQMASK, 32'h1);
		want_meas <= 16'h00c8;
		for (int i = 0; i < 200 && start_out !== 1'b1; i++) cyc(1);
		chk("start on pickup", start_out, 1'b1);
		chk("start on event", evt_out, 32'h1);
		chk("event time", evt_time, 32'(CYCLE_MS));
		cyc(50);
		chk("trip before delay", trip_out, 1'b0);
		chk("irq on start", irq, 1'b1);
		cyc(50);
		chk("trip at delay", trip_out, 1'b1);
		rd(REG_IRQSTAT);
		chk("irq status", v, 32'h5);
		cyc(2);
		chk("irq cleared", irq, 1'b0);
		wr(REG_RECSEL, 32'h0);
		rd(REG_RECINFO);
		chk("record start info", v, 32'h16d);
		rd(REG_RECFLT);
		chk("record current", v, 32'hc8);
		wr(REG_RECSEL, 32'h1);
		rd(REG_RECINFO);
		chk("record trip info", v, 32'h16f);
		rd(REG_RECREM);
		chk("remaining at trip", v, 32'h0);
		rd(REG_RECTIME);
		chk("record trip time", v, 32'(3 * CYCLE_MS));
		want_meas <= 16'h0062;
		cyc(60);
		chk("start in hysteresis", start_out, 1'b1);
		want_meas <= 16'h0060;
		cyc(60);
		chk("start dropped", start_out, 1'b0);
		want_block <= 1'b1;
		cyc(60);
		want_meas <= 16'h00c8;
		cyc(60);
		chk("blocked at pickup", blocked_out, 1'b1);
		chk("no start when blocked", start_out, 1'b0);
		want_block <= 1'b0;
		cyc(60);
		chk("start held off", start_out, 1'b0);
		want_meas <= 16'h0000;
		cyc(60);
		want_meas <= 16'h00c8;
		cyc(60);
		chk("restart", start_out, 1'b1);
		want_block <= 1'b1;
		cyc(60);
		chk("start dropped by block", start_out, 1'b0);
		chk("blocked during start", blocked_out, 1'b1);
		rd(REG_CNTSTART);
		chk("start count", v, 32'h2);
		rd(REG_CNTTRIP);
		chk("trip count", v, 32'h1);
		rd(REG_CNTBLK);
		chk("blocked count", v, 32'h2);
		rd(REG_STATUS);
		chk("record count", v & 32'h1fe0, 32'h0aa0);
		wr(REG_CTRL, 32'h4);
		rd(REG_CNTSTART);
		chk("start count cleared", v, 32'h0);
		wr(REG_CTRL, 32'h2);
		want_harm <= 16'h000a;
		want_block <= 1'b0;
		want_meas <= 16'h0000;
		cyc(60);
		want_meas <= 16'h00c8;
		cyc(200);
		chk("start under inrush", start_out, 1'b1);
		chk("trip held by inrush", trip_out, 1'b0);
		wr(REG_HLIMIT, 32'd2000);
		cyc(60);
		chk("trip above harmonic limit", trip_out, 1'b1);
		finish_test();
	end
endmodule : tb_efb_stage
`default_nettype wire
